// ===== verilog/ofd_defines.vh
// Purpose: constants for the operand field decoder
// Assumes: instruction bytes arrive one per strobe from the fetch queue
// Notes:   field positions refer to the addressing-mode byte
// What this block does
// - kind 01 one displacement byte, 10 two bytes, 11 register operand.
// - kind 00 fetches no displacement, except select 110 fetches direct address.
// - size clear selects byte registers, size set selects word registers.
// - register kind: second select names a register with same mapping.
// - size flag clear means byte, set means word, also immediate length.
// - memory kinds form location from base and index per select code.
// - two-byte displacement: first byte low, second byte high.
// - single displacement byte is sign-extended to 16 bits.
// - immediate bytes come only after all displacement bytes.
// - two-byte immediate: first byte low, second byte high.
// - segment code 00 extra, 01 code, 10 stack, 11 data.
// - sign-extended immediate form takes one byte, extends to 16 bits.
// - short branch offset is 8-bit signed added to pointer.
// - near branch offset is signed 16-bit, low byte then high.
// - direct offset used as operand location without base or index.
// - far transfer loads new pointer and code segment, low then high.
// - handoff opcode is group one from opcode, group two from next byte.
// - low displacement byte for both sizes, high byte only for 16-bit.
`ifndef OFD_DEFINES_VH
`define OFD_DEFINES_VH

`define OFD_KIND_HI        7
`define OFD_KIND_LO        6
`define OFD_FIRST_HI       5
`define OFD_FIRST_LO       3
`define OFD_SECOND_HI      2
`define OFD_SECOND_LO      0

`define OFD_KIND_NODISP    2'h0
`define OFD_KIND_DISP8     2'h1
`define OFD_KIND_DISP16    2'h2
`define OFD_KIND_REG       2'h3
`define OFD_SEL_DIRECT     3'h6

`define OFD_SEG_EXTRA      2'h0
`define OFD_SEG_CODE       2'h1
`define OFD_SEG_STACK      2'h2
`define OFD_SEG_DATA       2'h3

`define OFD_FORM_MODRM     3'h0
`define OFD_FORM_SHORT     3'h1
`define OFD_FORM_NEAR      3'h2
`define OFD_FORM_DIRECT    3'h3
`define OFD_FORM_FAR       3'h4
`define OFD_FORM_HANDOFF   3'h5

`endif

// ===== verilog/ofd_operand_field_decoder.v
// Purpose: decodes operand fields and trailing bytes of one instruction
// Assumes: one byte per in_valid cycle; start pulses with the opcode byte
// Notes:   register file values are read combinationally from the datapath
`timescale 1ns/1ps
`default_nettype none
`include "ofd_defines.vh"

module ofd_operand_field_decoder (
    input  wire        mclk,
    input  wire        rstn,
    input  wire        start,
    input  wire [2:0]  form,
    input  wire [7:0]  opcode_byte,
    input  wire        size_flag,
    input  wire        sign_ext,
    input  wire        has_immediate,
    input  wire        in_valid,
    input  wire [7:0]  in_byte,
    input  wire [15:0] instr_pointer,
    input  wire [15:0] base_word,
    input  wire [15:0] base_pointer,
    input  wire [15:0] source_index,
    input  wire [15:0] dest_index,
    output reg         busy,
    output reg         done,
    output reg         word_op,
    output reg         mem_operand,
    output reg  [3:0]  first_reg,
    output reg  [3:0]  second_reg,
    output reg  [15:0] operand_location,
    output reg  [15:0] immediate_value,
    output reg  [15:0] next_pointer,
    output reg  [15:0] new_code_segment,
    output reg         load_code_segment,
    output reg  [1:0]  segment_select,
    output reg  [5:0]  handoff_opcode
);

// ----------------------------------------------------------------
// byte sequencer states
// ----------------------------------------------------------------
localparam ST_IDLE  = 3'h0;
localparam ST_MODRM = 3'h1;
localparam ST_DISPL = 3'h2;
localparam ST_DISPH = 3'h3;
localparam ST_IMML  = 3'h4;
localparam ST_IMMH  = 3'h5;
localparam ST_FARL  = 3'h6;
localparam ST_FARH  = 3'h7;

reg [2:0]  state_reg;
reg [2:0]  form_reg;
reg [2:0]  group_one_reg;
reg        size_reg;
reg        sext_reg;
reg        imm_reg;
reg        seg_phase_reg;
reg [7:0]  low_reg;
reg [7:0]  modrm_reg;

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
// register code: bit 3 is the size flag, low bits the field code
function [3:0] reg_code;
    input       w;
    input [2:0] code;
    begin
        reg_code = {w, code};
    end
endfunction

function [15:0] sext8;
    input [7:0] b;
    begin
        sext8 = {{8{b[7]}}, b};
    end
endfunction

// base plus index part of the operand location
function [15:0] loc_base;
    input [2:0] sel;
    begin
        case (sel)
            3'h0:    loc_base = base_word + source_index;
            3'h1:    loc_base = base_word + dest_index;
            3'h2:    loc_base = base_pointer + source_index;
            3'h3:    loc_base = base_pointer + dest_index;
            3'h4:    loc_base = source_index;
            3'h5:    loc_base = dest_index;
            3'h6:    loc_base = base_pointer;
            default: loc_base = base_word;
        endcase
    end
endfunction

wire [1:0] kind_w   = in_byte[`OFD_KIND_HI:`OFD_KIND_LO];
wire [2:0] second_w = in_byte[`OFD_SECOND_HI:`OFD_SECOND_LO];
wire [1:0] kind_r   = modrm_reg[`OFD_KIND_HI:`OFD_KIND_LO];
wire [2:0] second_r = modrm_reg[`OFD_SECOND_HI:`OFD_SECOND_LO];
wire       direct_r = (kind_r == `OFD_KIND_NODISP) && (second_r == `OFD_SEL_DIRECT);
wire [2:0] after_disp = imm_reg ? ST_IMML : ST_IDLE;
// immediates of sign-extended form or byte size end after one byte
wire       imm_short = sext_reg | ~size_reg;
// handoff carries a full modrm byte, so its displacement follows the modrm path
wire       modrm_form = (form_reg == `OFD_FORM_MODRM) || (form_reg == `OFD_FORM_HANDOFF);
// read by the sequencer, so declared ahead of it
reg        next_idle;

// ----------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------
always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        state_reg         <= ST_IDLE;
        form_reg          <= 3'h0;
        group_one_reg     <= 3'h0;
        size_reg          <= 1'b0;
        sext_reg          <= 1'b0;
        imm_reg           <= 1'b0;
        seg_phase_reg     <= 1'b0;
        low_reg           <= 8'h00;
        modrm_reg         <= 8'h00;
        busy              <= 1'b0;
        done              <= 1'b0;
        word_op           <= 1'b0;
        mem_operand       <= 1'b0;
        first_reg         <= 4'h0;
        second_reg        <= 4'h0;
        operand_location  <= 16'h0000;
        immediate_value   <= 16'h0000;
        next_pointer      <= 16'h0000;
        new_code_segment  <= 16'h0000;
        load_code_segment <= 1'b0;
        segment_select    <= 2'h0;
        handoff_opcode    <= 6'h00;
    end else begin
        done <= 1'b0;
        if (state_reg == ST_IDLE) begin
            if (start) begin
                form_reg          <= form;
                size_reg          <= size_flag;
                sext_reg          <= sign_ext;
                imm_reg           <= has_immediate;
                group_one_reg     <= opcode_byte[2:0];
                word_op           <= size_flag;
                seg_phase_reg     <= 1'b0;
                load_code_segment <= 1'b0;
                busy              <= 1'b1;
                case (form)
                    `OFD_FORM_MODRM, `OFD_FORM_HANDOFF: state_reg <= ST_MODRM;
                    `OFD_FORM_SHORT, `OFD_FORM_NEAR,
                    `OFD_FORM_DIRECT:                   state_reg <= ST_DISPL;
                    `OFD_FORM_FAR:                      state_reg <= ST_FARL;
                    default:                            state_reg <= ST_IDLE;
                endcase
                if (form > `OFD_FORM_HANDOFF)
                    busy <= 1'b0;
            end
        end else if (in_valid) begin
            case (state_reg)
                ST_MODRM: begin
                    modrm_reg      <= in_byte;
                    segment_select <= in_byte[4:3];
                    first_reg      <= reg_code(size_reg, in_byte[5:3]);
                    second_reg     <= reg_code(size_reg, second_w);
                    mem_operand    <= (kind_w != `OFD_KIND_REG);
                    if (form_reg == `OFD_FORM_HANDOFF)
                        handoff_opcode <= {group_one_reg, in_byte[5:3]};
                    operand_location <= loc_base(second_w);
                    case (kind_w)
                        `OFD_KIND_DISP8, `OFD_KIND_DISP16: state_reg <= ST_DISPL;
                        `OFD_KIND_NODISP:
                            state_reg <= (second_w == `OFD_SEL_DIRECT) ? ST_DISPL
                                                                       : after_disp;
                        default: state_reg <= after_disp;
                    endcase
                end
                ST_DISPL: begin
                    low_reg <= in_byte;
                    if (form_reg == `OFD_FORM_SHORT) begin
                        next_pointer <= instr_pointer + sext8(in_byte);
                        state_reg    <= ST_IDLE;
                    end else if (modrm_form && kind_r == `OFD_KIND_DISP8) begin
                        // 16-bit add, carry out dropped
                        operand_location <= operand_location + sext8(in_byte);
                        state_reg        <= after_disp;
                    end else begin
                        state_reg <= ST_DISPH;
                    end
                end
                ST_DISPH: begin
                    if (form_reg == `OFD_FORM_NEAR)
                        next_pointer <= instr_pointer + {in_byte, low_reg};
                    else if (form_reg == `OFD_FORM_DIRECT || direct_r)
                        operand_location <= {in_byte, low_reg};
                    else
                        operand_location <= operand_location + {in_byte, low_reg};
                    state_reg <= (modrm_form || form_reg == `OFD_FORM_DIRECT) ? after_disp
                                                                               : ST_IDLE;
                end
                ST_IMML: begin
                    low_reg <= in_byte;
                    if (imm_short) begin
                        immediate_value <= sext_reg ? sext8(in_byte) : {8'h00, in_byte};
                        state_reg       <= ST_IDLE;
                    end else begin
                        state_reg <= ST_IMMH;
                    end
                end
                ST_IMMH: begin
                    immediate_value <= {in_byte, low_reg};
                    state_reg       <= ST_IDLE;
                end
                ST_FARL: begin
                    low_reg   <= in_byte;
                    state_reg <= ST_FARH;
                end
                ST_FARH: begin
                    // pointer first, then code segment
                    if (!seg_phase_reg) begin
                        next_pointer  <= {in_byte, low_reg};
                        seg_phase_reg <= 1'b1;
                        state_reg     <= ST_FARL;
                    end else begin
                        new_code_segment  <= {in_byte, low_reg};
                        load_code_segment <= 1'b1;
                        state_reg         <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
        if (state_reg != ST_IDLE && in_valid && next_idle) begin
            busy <= 1'b0;
            done <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// end of instruction detection (mirrors the sequencer's exits)
// ----------------------------------------------------------------
always @* begin
    next_idle = 1'b0;
    case (state_reg)
        ST_MODRM: next_idle = (kind_w == `OFD_KIND_REG ||
                               (kind_w == `OFD_KIND_NODISP && second_w != `OFD_SEL_DIRECT))
                              && !imm_reg;
        ST_DISPL: next_idle = (form_reg == `OFD_FORM_SHORT) ||
                              (modrm_form && kind_r == `OFD_KIND_DISP8 && !imm_reg);
        ST_DISPH: next_idle = !((modrm_form || form_reg == `OFD_FORM_DIRECT) && imm_reg);
        ST_IMML:  next_idle = imm_short;
        ST_IMMH:  next_idle = 1'b1;
        ST_FARH:  next_idle = seg_phase_reg;
        default:  next_idle = 1'b0;
    endcase
end

endmodule
`default_nettype wire

// ===== verif/ofd_fetch_model.sv
// Purpose: fetch queue model handing instruction bytes to the decoder
// Assumes: caller enters send just after a rising edge
// Notes:   an idle byte lane shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module ofd_fetch_model (
    input  wire logic       mclk,
    output var  logic       in_valid,
    output var  logic [7:0] in_byte
);
    initial begin
        in_valid = 1'b0;
        in_byte  = 8'h00;
    end
    // bytes go out in stream order, gap idle cycles between them
    task automatic send(input logic [7:0] b[$], input int gap);
        foreach (b[i]) begin
            if (i > 0 && gap > 0) begin
                in_valid = 1'b0;
                in_byte  = ~in_byte;
                repeat (gap) @(posedge mclk);
                #1;
            end
            in_valid = 1'b1;
            in_byte  = b[i];
            @(posedge mclk);
            #1;
        end
        in_valid = 1'b0;
        in_byte  = ~in_byte;
    endtask
endmodule
`default_nettype wire

// ===== verif/ofd_operand_field_decoder_assertions.sv
// Purpose: port-level checks on the operand field decoder
// Assumes: modrm is the first byte after a start of form 0 or 5
// Notes:   datapath inputs are not watched here
`timescale 1ns/1ps
`default_nettype none
module ofd_operand_field_decoder_assertions (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic       start,
    input wire logic [2:0] form,
    input wire logic       size_flag,
    input wire logic       in_valid,
    input wire logic [7:0] in_byte,
    input wire logic       busy,
    input wire logic       done,
    input wire logic       word_op,
    input wire logic       mem_operand,
    input wire logic [3:0] first_reg,
    input wire logic [3:0] second_reg,
    input wire logic [1:0] segment_select,
    input wire logic       load_code_segment
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic modrm_wait_reg;
    always_ff @(posedge mclk or negedge rstn)
        if (!rstn) modrm_wait_reg <= 1'b0;
        else if (start && !busy) modrm_wait_reg <= (form == 3'h0) || (form == 3'h5);
        else if (busy && in_valid) modrm_wait_reg <= 1'b0;
    sequence s_modrm; busy && in_valid && modrm_wait_reg; endsequence
    sequence s_accept; start && !busy; endsequence
    property p_first; s_modrm |=> first_reg == {$past(size_flag), $past(in_byte[5:3])}; endproperty
    property p_second;
        s_modrm ##0 (in_byte[7:6] == 2'h3) |=> second_reg == {$past(size_flag), $past(in_byte[2:0])};
    endproperty
    property p_kind;
        s_modrm |=> mem_operand == ($past(in_byte[7:6]) != 2'h3) && word_op == $past(size_flag);
    endproperty
    property p_seg; s_modrm |=> segment_select == $past(in_byte[4:3]); endproperty
    property p_done_end; done |-> !busy ##1 !done; endproperty
    property p_done_cause; done |-> $past(busy) && $past(in_valid); endproperty
    property p_busy_start; s_accept ##0 (form < 3'h6) |=> busy; endproperty
    property p_idle; !busy && !start |=> !busy; endproperty
    property p_far_clear; s_accept |=> !load_code_segment; endproperty
    a_first: assert property (p_first) else $error("first register wrong");
    a_second: assert property (p_second) else $error("second register wrong");
    a_kind: assert property (p_kind) else $error("operand kind wrong");
    a_seg: assert property (p_seg) else $error("segment code wrong");
    a_done_end: assert property (p_done_end) else $error("done not a pulse");
    a_done_cause: assert property (p_done_cause) else $error("done without byte");
    a_busy_start: assert property (p_busy_start) else $error("start not taken");
    a_idle: assert property (p_idle) else $error("busy while idle");
    a_far_clear: assert property (p_far_clear) else $error("segment load stuck");
endmodule
bind ofd_operand_field_decoder ofd_operand_field_decoder_assertions i_chk (
    .mclk(mclk), .rstn(rstn), .start(start), .form(form), .size_flag(size_flag),
    .in_valid(in_valid), .in_byte(in_byte), .busy(busy), .done(done), .word_op(word_op),
    .mem_operand(mem_operand), .first_reg(first_reg), .second_reg(second_reg),
    .segment_select(segment_select), .load_code_segment(load_code_segment));
`default_nettype wire

// ===== verif/tb.sv
// Purpose: self-checking bench for the operand field decoder
// Assumes: datapath registers held constant through the run
// Notes:   expectations worked out by hand from the fixed register values
`timescale 1ns/1ps
`default_nettype none
`define OFD_CHECK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb;
    logic mclk = 1'b0, rstn = 1'b0, start = 1'b0, size_flag = 1'b0, sign_ext = 1'b0;
    logic has_immediate = 1'b0, in_valid, busy, done, word_op, mem_operand, load_code_segment;
    logic [2:0] form = 3'h0;
    logic [7:0] opcode_byte = 8'h00, in_byte;
    logic [3:0] first_reg, second_reg;
    logic [1:0] segment_select;
    logic [5:0] handoff_opcode;
    logic [15:0] operand_location, immediate_value, next_pointer, new_code_segment;
    int errors = 0, checks_done = 0;
    always #2.5 mclk = ~mclk;
    ofd_fetch_model i_fm (.mclk(mclk), .in_valid(in_valid), .in_byte(in_byte));
    ofd_operand_field_decoder i_dut (.mclk(mclk), .rstn(rstn), .start(start), .form(form),
        .opcode_byte(opcode_byte), .size_flag(size_flag), .sign_ext(sign_ext),
        .has_immediate(has_immediate), .in_valid(in_valid), .in_byte(in_byte),
        .instr_pointer(16'h4000), .base_word(16'h1000), .base_pointer(16'hF000),
        .source_index(16'h0200), .dest_index(16'h1100), .busy(busy), .done(done),
        .word_op(word_op), .mem_operand(mem_operand), .first_reg(first_reg),
        .second_reg(second_reg), .operand_location(operand_location),
        .immediate_value(immediate_value), .next_pointer(next_pointer),
        .new_code_segment(new_code_segment), .load_code_segment(load_code_segment),
        .segment_select(segment_select), .handoff_opcode(handoff_opcode));
    // --------------------------------
    // shared driver and closing
    // --------------------------------
    task automatic run(input logic [2:0] f, input logic s, input logic x, input logic h,
                       input logic [7:0] b[$], input int gap);
        form = f;
        size_flag = s;
        sign_ext = x;
        has_immediate = h;
        start = 1'b1;
        @(posedge mclk);
        #1 start = 1'b0;
        i_fm.send(b, gap);
        `OFD_CHECK("done", 1'b1, done);
        `OFD_CHECK("busy", 1'b0, busy);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_regs();
        logic [2:0] c;
        for (int i = 0; i < 16; i++) begin
            c = i[2:0];
            run(3'h0, i[3], 1'b0, 1'b0, '{{2'h3, c, 3'h7 - c}}, 0);
            `OFD_CHECK("first", {i[3], c}, first_reg);
            `OFD_CHECK("second", {i[3], 3'h7 - c}, second_reg);
            `OFD_CHECK("seg", c[1:0], segment_select);
            `OFD_CHECK("reg kind mem", 1'b0, mem_operand);
            `OFD_CHECK("word op", i[3], word_op);
        end
        $display("t_regs finished");
    endtask
    task automatic t_mem();
        run(3'h0, 1'b1, 1'b0, 1'b0, '{8'h00}, 0);
        `OFD_CHECK("loc bx+si", 16'h1200, operand_location);
        `OFD_CHECK("mem kind", 1'b1, mem_operand);
        run(3'h0, 1'b1, 1'b0, 1'b0, '{8'h41, 8'h00}, 0);
        `OFD_CHECK("loc bx+di", 16'h2100, operand_location);
        run(3'h0, 1'b1, 1'b0, 1'b0, '{8'h42, 8'h10}, 0);
        `OFD_CHECK("loc bp+si", 16'hF210, operand_location);
        run(3'h0, 1'b1, 1'b0, 1'b0, '{8'h45, 8'h80}, 0);
        `OFD_CHECK("loc di", 16'h1080, operand_location);
        run(3'h0, 1'b1, 1'b0, 1'b0, '{8'h46, 8'h10}, 0);
        `OFD_CHECK("loc bp", 16'hF010, operand_location);
        run(3'h0, 1'b1, 1'b0, 1'b0, '{8'h47, 8'hFE}, 2);
        `OFD_CHECK("loc disp8", 16'h0FFE, operand_location);
        run(3'h0, 1'b1, 1'b0, 1'b0, '{8'h8B, 8'h34, 8'h12}, 0);
        `OFD_CHECK("loc disp16", 16'h1334, operand_location);
        run(3'h0, 1'b1, 1'b0, 1'b0, '{8'h06, 8'h78, 8'h56}, 1);
        `OFD_CHECK("loc direct", 16'h5678, operand_location);
        $display("t_mem finished");
    endtask
    task automatic t_imm();
        run(3'h0, 1'b1, 1'b0, 1'b1, '{8'h44, 8'h05, 8'hCD, 8'hAB}, 0);
        `OFD_CHECK("loc si+5", 16'h0205, operand_location);
        `OFD_CHECK("imm16", 16'hABCD, immediate_value);
        run(3'h0, 1'b1, 1'b1, 1'b1, '{8'hC0, 8'h80}, 0);
        `OFD_CHECK("imm sx", 16'hFF80, immediate_value);
        run(3'h0, 1'b0, 1'b0, 1'b1, '{8'hC0, 8'h80}, 0);
        `OFD_CHECK("imm8", 16'h0080, immediate_value);
        $display("t_imm finished");
    endtask
    task automatic t_branch();
        run(3'h1, 1'b0, 1'b0, 1'b0, '{8'hF0}, 0);
        `OFD_CHECK("short", 16'h3FF0, next_pointer);
        run(3'h2, 1'b0, 1'b0, 1'b0, '{8'h34, 8'hF2}, 1);
        `OFD_CHECK("near", 16'h3234, next_pointer);
        run(3'h3, 1'b0, 1'b0, 1'b0, '{8'h78, 8'h56}, 0);
        `OFD_CHECK("direct", 16'h5678, operand_location);
        run(3'h4, 1'b0, 1'b0, 1'b0, '{8'h11, 8'h22, 8'h33, 8'h44}, 0);
        `OFD_CHECK("far ptr", 16'h2211, next_pointer);
        `OFD_CHECK("far cs", 16'h4433, new_code_segment);
        `OFD_CHECK("far load", 1'b1, load_code_segment);
        opcode_byte = 8'hDD;
        run(3'h5, 1'b0, 1'b0, 1'b0, '{8'hD8}, 0);
        `OFD_CHECK("handoff", 6'h2B, handoff_opcode);
        run(3'h5, 1'b0, 1'b0, 1'b0, '{8'h5E, 8'h7F}, 0);
        `OFD_CHECK("handoff mem loc", 16'hF07F, operand_location);
        `OFD_CHECK("handoff mem op", 6'h2B, handoff_opcode);
        form = 3'h6;
        start = 1'b1;
        @(posedge mclk);
        #1 start = 1'b0;
        `OFD_CHECK("bad form busy", 1'b0, busy);
        $display("t_branch finished");
    endtask
    task automatic t_reset();
        rstn = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        `OFD_CHECK("rst ptr", 16'h0000, next_pointer);
        `OFD_CHECK("rst handoff", 6'h00, handoff_opcode);
        `OFD_CHECK("rst loc", 16'h0000, operand_location);
        rstn = 1'b1;
        run(3'h4, 1'b0, 1'b0, 1'b0, '{8'h01, 8'h80, 8'hFF, 8'h7F}, 0);
        `OFD_CHECK("far ptr 2", 16'h8001, next_pointer);
        `OFD_CHECK("far cs 2", 16'h7FFF, new_code_segment);
        `OFD_CHECK("far load 2", 1'b1, load_code_segment);
        $display("t_reset finished");
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        #1 rstn = 1'b1;
        @(posedge mclk);
        #1;
        t_regs();
        t_mem();
        t_imm();
        t_branch();
        t_reset();
        complete_run();
    end
    // limit well above the roughly 120 cycles the tests need
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
